// ---- cmp_pkg.sv ----
// Purpose: shared constants for the dual comparator control block
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package cmp_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  CTRL_OFFSET     = 8'h9C;
	localparam logic [7:0]  IRQ_STAT_OFFSET = 8'hA0;
	localparam logic [7:0]  IRQ_MASK_OFFSET = 8'hA4;
	localparam logic [7:0]  CTRL_RESET      = 8'h07;
	localparam logic [7:0]  CTRL_WR_MASK    = 8'h3F;
	localparam int          MODE_LSB        = 0;
	localparam int          SWITCH_BIT      = 3;
	localparam int          INV1_BIT        = 4;
	localparam int          INV2_BIT        = 5;
	localparam int          RES1_BIT        = 6;
	localparam int          RES2_BIT        = 7;
	localparam logic [2:0]  MODE_INTREF     = 3'h6;
	localparam logic [2:0]  MODE_SWITCHED   = 3'h2;
	localparam logic [2:0]  MODE_OFF        = 3'h7;
	localparam logic [2:0]  MODE_ZERO       = 3'h0;
	localparam logic [2:0]  MODE_ROUTED     = 3'h3;
	localparam logic [2:0]  MODE_SINGLE     = 3'h5;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : cmp_pkg

// ---- cmp_route_if.sv ----
// Purpose: carries route settings from control to the mux
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/100ps
interface cmp_route_if;
	logic [2:0] mode;
	logic       sw;
	logic [1:0] inv;
	logic [1:0] result;
	logic [1:0] out_route;
	modport ctrl (output mode, output sw, output inv, input result, input out_route);
	modport mux  (input mode, input sw, input inv, output result, output out_route);
endinterface : cmp_route_if

// ---- cmp_route_mux.sv ----
// Purpose: per-mode selection of comparator results and output routing
// Assumes: raw comparator decisions arrive as digital levels per input pair
// Notes:   combinational; the top registers everything it drives out
`timescale 1ns/100ps
module cmp_route_mux (
	cmp_route_if.mux    rt,
	input  wire logic [3:0] pin_cmp,
	input  wire logic [1:0] ref_cmp
);
	logic [1:0] raw;

	// raw decision per channel; pin_cmp[i] is pin pair decision, ref_cmp uses internal ref
	always_comb
	begin
		raw = pin_cmp[1:0];
		rt.out_route = 2'h0;
		unique case (rt.mode)
			cmp_pkg::MODE_ZERO, cmp_pkg::MODE_OFF: raw = 2'h0;       // both off
			cmp_pkg::MODE_INTREF: raw = ref_cmp;
			cmp_pkg::MODE_SWITCHED: raw = rt.sw ? pin_cmp[3:2] : pin_cmp[1:0];
			cmp_pkg::MODE_ROUTED:
			begin
				raw          = pin_cmp[1:0];
				rt.out_route = 2'h3;
			end
			cmp_pkg::MODE_SINGLE: raw = {pin_cmp[1], 1'b0};           // one channel only
			default: raw = pin_cmp[1:0];
		endcase
	end

	// per-channel polarity, low when plus below minus before inversion
	assign rt.result = raw ^ rt.inv;
endmodule : cmp_route_mux

// ---- cmp_ctrl_axi.sv ----
// Purpose: AXI4-Lite control/status for a dual comparator unit
// Assumes: raw comparator levels synchronous to aclk
// Notes:   result change sets a sticky interrupt status bit
`timescale 1ns/100ps
// Overview of operation
// - two comparators, each with a result bit
// - four input pins, two routed outputs
// - three-bit mode field in low bits
// - result high when plus above minus
// - mode 110 uses internal reference
// - port direction still governs pins
// - shared or separate external reference
// - result bits are read only
// - invert bit flips register and pin
// - reset puts mode at 111
module cmp_ctrl_axi (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [3:0]  pin_cmp,
	input  wire logic [1:0]  ref_cmp,
	input  wire logic [1:0]  port_dir_in,
	output logic [1:0]       out_pin_o,
	output logic [1:0]       out_pin_oe,
	output logic             irq
);
	cmp_route_if rt ();

	logic [7:0]  ctrl_reg, ctrl_next;
	logic [1:0]  res_reg, res_next;
	logic [1:0]  stat_reg, stat_next;
	logic [1:0]  mask_reg, mask_next;
	logic        aw_reg, aw_next;
	logic        w_reg, w_next;
	logic [7:0]  awa_reg, awa_next;
	logic [7:0]  wd_reg, wd_next;
	logic        wstb_reg, wstb_next;
	logic        bv_reg, bv_next;
	logic [1:0]  br_reg, br_next;
	logic        rv_reg, rv_next;
	logic [31:0] rd_reg, rd_next;
	logic [1:0]  rr_reg, rr_next;
	logic [1:0]  po_reg, po_next;
	logic [1:0]  poe_reg, poe_next;
	logic        irq_reg, irq_next;
	logic        awrdy_reg, awrdy_next;
	logic        wrdy_reg, wrdy_next;
	logic        arrdy_reg, arrdy_next;
	logic        do_wr;

	// address decode shared by both channels
	function automatic logic known(input logic [7:0] a);
		known = (a == cmp_pkg::CTRL_OFFSET) || (a == cmp_pkg::IRQ_STAT_OFFSET)
			|| (a == cmp_pkg::IRQ_MASK_OFFSET);
	endfunction : known

	assign rt.mode = ctrl_reg[cmp_pkg::MODE_LSB +: 3];
	assign rt.sw   = ctrl_reg[cmp_pkg::SWITCH_BIT];
	assign rt.inv  = {ctrl_reg[cmp_pkg::INV2_BIT], ctrl_reg[cmp_pkg::INV1_BIT]};

	cmp_route_mux u_mux (
		.rt      (rt.mux),
		.pin_cmp (pin_cmp),
		.ref_cmp (ref_cmp)
	);

	// write path, status, results, pins
	always_comb
	begin
		aw_next   = aw_reg;
		w_next    = w_reg;
		awa_next  = awa_reg;
		wd_next   = wd_reg;
		wstb_next = wstb_reg;
		bv_next   = bv_reg;
		br_next   = br_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		if (s_axi_awvalid && !aw_reg)
		begin
			aw_next  = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_reg)
		begin
			w_next    = 1'b1;
			wd_next   = s_axi_wdata[7:0];
			wstb_next = s_axi_wstrb[0];
		end
		do_wr = aw_reg && w_reg && !bv_reg;
		if (do_wr)
		begin
			aw_next = 1'b0;
			w_next  = 1'b0;
			bv_next = 1'b1;
			br_next = known(awa_reg) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
			if (wstb_reg && awa_reg == cmp_pkg::CTRL_OFFSET)
				ctrl_next = (wd_reg & cmp_pkg::CTRL_WR_MASK);
			if (wstb_reg && awa_reg == cmp_pkg::IRQ_MASK_OFFSET)
				mask_next = wd_reg[1:0];
		end
		else if (bv_reg && s_axi_bready)
			bv_next = 1'b0;
		res_next  = rt.result;
		stat_next = stat_reg;
		if (do_wr && wstb_reg && awa_reg == cmp_pkg::IRQ_STAT_OFFSET)
			stat_next = stat_reg & ~wd_reg[1:0];
		stat_next = stat_next | (res_next ^ res_reg); // set wins over clear
		irq_next  = |(stat_next & mask_next);
		po_next   = rt.result & rt.out_route;
		poe_next  = rt.out_route & ~port_dir_in;
		awrdy_next = !aw_next; // readies come from flops too
		wrdy_next  = !w_next;
	end

	// read path
	always_comb
	begin
		rv_next = rv_reg;
		rd_next = rd_reg;
		rr_next = rr_reg;
		if (s_axi_arvalid && !rv_reg)
		begin
			rv_next = 1'b1;
			rr_next = known(s_axi_araddr) ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				cmp_pkg::CTRL_OFFSET:     rd_next = {24'h000000, res_reg, ctrl_reg[5:0]};
				cmp_pkg::IRQ_STAT_OFFSET: rd_next = {30'h0, stat_reg};
				cmp_pkg::IRQ_MASK_OFFSET: rd_next = {30'h0, mask_reg};
				default:                  rd_next = 32'h00000000;
			endcase
		end
		else if (rv_reg && s_axi_rready)
			rv_next = 1'b0;
		arrdy_next = !rv_next;
	end

	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= cmp_pkg::CTRL_RESET;
			res_reg  <= 2'h0;
			stat_reg <= 2'h0;
			mask_reg <= 2'h0;
			aw_reg   <= 1'b0;
			w_reg    <= 1'b0;
			awa_reg  <= 8'h00;
			wd_reg   <= 8'h00;
			wstb_reg <= 1'b0;
			bv_reg   <= 1'b0;
			br_reg   <= 2'h0;
			rv_reg   <= 1'b0;
			rd_reg   <= 32'h00000000;
			rr_reg   <= 2'h0;
			po_reg   <= 2'h0;
			poe_reg  <= 2'h0;
			irq_reg  <= 1'b0;
			awrdy_reg <= 1'b1;
			wrdy_reg  <= 1'b1;
			arrdy_reg <= 1'b1;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			res_reg  <= res_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			aw_reg   <= aw_next;
			w_reg    <= w_next;
			awa_reg  <= awa_next;
			wd_reg   <= wd_next;
			wstb_reg <= wstb_next;
			bv_reg   <= bv_next;
			br_reg   <= br_next;
			rv_reg   <= rv_next;
			rd_reg   <= rd_next;
			rr_reg   <= rr_next;
			po_reg   <= po_next;
			poe_reg  <= poe_next;
			irq_reg  <= irq_next;
			awrdy_reg <= awrdy_next;
			wrdy_reg  <= wrdy_next;
			arrdy_reg <= arrdy_next;
		end
	end

	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready  = wrdy_reg;
	assign s_axi_bvalid  = bv_reg;
	assign s_axi_bresp   = br_reg;
	assign s_axi_arready = arrdy_reg;
	assign s_axi_rvalid  = rv_reg;
	assign s_axi_rdata   = rd_reg;
	assign s_axi_rresp   = rr_reg;
	assign out_pin_o     = po_reg;
	assign out_pin_oe    = poe_reg;
	assign irq           = irq_reg;

	// rule and protocol checks
	property p_reset_mode;
		@(posedge aclk) !aresetn |=> ctrl_reg[2:0] == cmp_pkg::MODE_OFF;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode not off after reset");

	property p_ro_results;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && wstb_reg && awa_reg == cmp_pkg::CTRL_OFFSET)
			|=> ctrl_reg[7:6] == 2'h0 && ctrl_reg[5:0] == $past(wd_reg[5:0]);
	endproperty
	a_ro_results: assert property (p_ro_results) else $error("result bits written");

	property p_result_track;
		@(posedge aclk) disable iff (!aresetn) 1'b1 |=> res_reg == $past(rt.result);
	endproperty
	a_result_track: assert property (p_result_track) else $error("result not tracked");

	property p_intref;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_INTREF) |-> rt.result == (ref_cmp ^ rt.inv);
	endproperty
	a_intref: assert property (p_intref) else $error("internal reference not used");

	property p_switch;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_SWITCHED && rt.sw) |-> rt.result == (pin_cmp[3:2] ^ rt.inv);
	endproperty
	a_switch: assert property (p_switch) else $error("switch not honoured");

	property p_dir;
		@(posedge aclk) disable iff (!aresetn)
		(port_dir_in == 2'h3) |=> out_pin_oe == 2'h0;
	endproperty
	a_dir: assert property (p_dir) else $error("pin driven while input");

	property p_pin_inv;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_ROUTED) |=> out_pin_o == res_reg;
	endproperty
	a_pin_inv: assert property (p_pin_inv) else $error("pin polarity wrong");

	property p_off_mode;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_OFF) |-> rt.result == rt.inv;
	endproperty
	a_off_mode: assert property (p_off_mode) else $error("off mode gives result");

	property p_polarity;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == 3'h1 && rt.inv == 2'h0) |-> rt.result == pin_cmp[1:0];
	endproperty
	a_polarity: assert property (p_polarity) else $error("raw polarity wrong");

	property p_pin_quiet;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode != cmp_pkg::MODE_ROUTED) |=> out_pin_o == 2'h0 && out_pin_oe == 2'h0;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("pin driven unrouted");

	property p_oe_routed;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_ROUTED) |=> out_pin_oe == ~$past(port_dir_in);
	endproperty
	a_oe_routed: assert property (p_oe_routed) else $error("routed enable wrong");

	property p_ro_read;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == cmp_pkg::CTRL_OFFSET)
			|=> s_axi_rdata[7:6] == $past(res_reg);
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("result bits not read back");

	property p_stat_set;
		@(posedge aclk) disable iff (!aresetn)
		(rt.result != res_reg)
			|=> (stat_reg & $past(rt.result ^ res_reg)) == $past(rt.result ^ res_reg);
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("change not recorded");

	property p_irq_level;
		@(posedge aclk) disable iff (!aresetn)
		irq == |(stat_reg & mask_reg);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_single;
		@(posedge aclk) disable iff (!aresetn)
		(rt.mode == cmp_pkg::MODE_SINGLE) |-> rt.result[0] == rt.inv[0];
	endproperty
	a_single: assert property (p_single) else $error("unused channel active");
endmodule : cmp_ctrl_axi

// ---- analog_side.sv ----
// Purpose: far-side model of the comparator input pins and reference
// Assumes: analog decisions arrive already as digital levels
// Notes:   levels change just after a rising edge
`timescale 1ns/100ps
module analog_side (
	input  wire logic       aclk,
	input  wire logic [3:0] want_pin,
	input  wire logic [1:0] want_ref,
	input  wire logic [1:0] want_dir,
	output logic      [3:0] pin_cmp,
	output logic      [1:0] ref_cmp,
	output logic      [1:0] port_dir_in
);
	// present the requested pin, reference and direction levels
	always_ff @(posedge aclk)
	begin
		pin_cmp     <= want_pin;
		ref_cmp     <= want_ref;
		port_dir_in <= want_dir;
	end
endmodule : analog_side

// ---- tb_top.sv ----
// Purpose: self-checking bench for the dual comparator control block
// Assumes: bus tasks start on a rising edge, every wait is bounded
// Notes:   a reference function predicts the control reads that follow writes; reset reads expect 0x07
`timescale 1ns/100ps
module tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, c;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb = 4'hF, pin_cmp, want_pin = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ref_cmp, port_dir_in, out_pin_o, out_pin_oe, rsp;
	logic [1:0]  want_ref = '0, want_dir = 2'h3;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	int          n_errors = 0, tests_run = 0;

	// 250 MHz clock
	always #2 aclk = ~aclk;

	cmp_ctrl_axi dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_cmp, .ref_cmp,
		.port_dir_in, .out_pin_o, .out_pin_oe, .irq);
	analog_side far_u (.aclk, .want_pin, .want_ref, .want_dir, .pin_cmp, .ref_cmp,
		.port_dir_in);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic hang(input logic bad);
		if (bad)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: bus wait ran out", $time);
			tally_and_finish();
		end
	endtask : hang

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
		end while (!s_axi_bvalid && n < 64);
		rsp = s_axi_bresp;
		hang(!s_axi_bvalid);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b0;
		end while (!s_axi_rvalid && n < 64);
		rd_d = s_axi_rdata;
		rsp  = s_axi_rresp;
		hang(!s_axi_rvalid);
	endtask : rd

	// expected result pair {ch2, ch1} after mode mux and inversion
	function automatic logic [1:0] model(input logic [7:0] k, input logic [3:0] p,
		input logic [1:0] r);
		logic [1:0] raw;
		case (k[2:0])
			3'h0, 3'h7: raw = 2'h0;
			3'h2:       raw = k[3] ? p[3:2] : p[1:0];
			3'h5:       raw = {p[1], 1'b0};
			3'h6:       raw = r;
			default:    raw = p[1:0];
		endcase
		return raw ^ k[5:4];
	endfunction : model

	// main sequence
	initial
	begin
		int i;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(83738));
		rd(cmp_pkg::CTRL_OFFSET);
		chk(rd_d, 32'h0000_0007, "reset ctrl");
		for (i = 0; i < 32; i++)
		begin
			c = 8'($urandom);
			c[2:0] = 3'(i);
			want_pin <= 4'($urandom);
			want_ref <= 2'($urandom);
			want_dir <= 2'($urandom);
			wr(cmp_pkg::IRQ_MASK_OFFSET, 32'h0);
			wr(cmp_pkg::CTRL_OFFSET, {24'h0, c});
			chk(32'(rsp), 32'(cmp_pkg::RESP_OKAY), "ctrl write resp");
			repeat (4) @(posedge aclk);
			rd(cmp_pkg::CTRL_OFFSET);
			chk(rd_d, {24'h0, model(c, want_pin, want_ref), c[5:0]}, "ctrl");
			chk({30'h0, out_pin_oe}, (c[2:0] == cmp_pkg::MODE_ROUTED) ?
				{30'h0, ~want_dir} : 32'h0, "oe");
			chk({30'h0, out_pin_o}, (c[2:0] == cmp_pkg::MODE_ROUTED) ?
				{30'h0, model(c, want_pin, want_ref)} : 32'h0, "pin level");
		end
		rd(8'h10);
		chk(32'(rsp), 32'(cmp_pkg::RESP_SLVERR), "unmapped read");
		chk(rd_d, 32'h0, "unmapped data");
		wr(8'h10, 32'h0);
		chk(32'(rsp), 32'(cmp_pkg::RESP_SLVERR), "unmapped write");
		// change events set status, mask gates irq, write one clears
		want_pin <= 4'h0;
		wr(cmp_pkg::CTRL_OFFSET, 32'h01);
		repeat (4) @(posedge aclk);
		wr(cmp_pkg::IRQ_STAT_OFFSET, 32'h3);
		wr(cmp_pkg::IRQ_MASK_OFFSET, 32'h1);
		want_pin <= 4'h2;
		repeat (4) @(posedge aclk);
		rd(cmp_pkg::IRQ_STAT_OFFSET);
		chk(rd_d, 32'h2, "status ch2");
		chk(32'(irq), 32'h0, "irq masked");
		want_pin <= 4'h3;
		repeat (4) @(posedge aclk);
		chk(32'(irq), 32'h1, "irq raised");
		wr(cmp_pkg::IRQ_STAT_OFFSET, 32'h1);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0, "irq cleared");
		rd(cmp_pkg::IRQ_STAT_OFFSET);
		chk(rd_d, 32'h2, "status left");
		// a write with lane 0 disabled leaves control alone
		s_axi_wstrb <= 4'h0;
		wr(cmp_pkg::CTRL_OFFSET, 32'h05);
		chk(32'(rsp), 32'(cmp_pkg::RESP_OKAY), "masked write resp");
		s_axi_wstrb <= 4'hF;
		rd(cmp_pkg::CTRL_OFFSET);
		chk(rd_d, {24'h0, model(8'h01, 4'h3, 2'h0), 6'h01}, "masked write");
		wr(cmp_pkg::IRQ_MASK_OFFSET, 32'h3);
		chk(32'(irq), 32'h1, "irq from ch2");
		// mid-run reset returns control and irq to idle
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'(irq), 32'h0, "irq after reset");
		rd(cmp_pkg::CTRL_OFFSET);
		chk(rd_d, 32'h0000_0007, "ctrl after reset");
		chk({30'h0, out_pin_o}, 32'h0, "pins after reset");
		tally_and_finish();
	end
endmodule : tb_top
